// *** bench/gpm_pad_model.sv ***
/*
 * Pad model for the 32 port pins: the block's drivers, an external driver
 * per pin chosen by the bench, the on-chip pull-ups and floating pins.
 * Assumes it is clocked by the system clock of the block.
 */
`timescale 1ns/100ps
module gpm_pad_model (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_out,
	input  wire logic [31:0] i_oe_n,
	input  wire logic [31:0] i_pullup,
	input  wire logic [31:0] i_ext,
	input  wire logic [31:0] i_ext_en,
	output logic      [31:0] o_pad
);
	logic [31:0] last_r = 32'h0;

	always_comb begin
		for (int b = 0; b < 32; b++) begin
			if (!i_oe_n[b])
				o_pad[b] = i_out[b];
			else if (i_ext_en[b])
				o_pad[b] = i_ext[b];
			else if (i_pullup[b])
				o_pad[b] = 1'b1;
			else
				o_pad[b] = ~last_r[b];
		end
	end

	// floating pins toggle so no stale level is read
	always_ff @(posedge i_clk) begin
		last_r <= o_pad;
	end
endmodule : gpm_pad_model

// *** bench/gpm_top_tb.sv ***
/*
 * Self-checking bench of the port and gate-drive block: register bus
 * tasks, pad model on the pins, peripheral and phase sources driven here.
 * Assumes the register map of gpm_map.svh and one 25 MHz clock.
 */
`timescale 1ns/100ps
module gpm_top_tb;
	logic        I_CLK_SYS = 1'b0;
	logic        I_RST_N   = 1'b0;
	logic [15:0] addr      = 16'h0000;
	logic [7:0]  wdata     = 8'h00;
	logic        wr = 1'b0, rd = 1'b0, rmw = 1'b0;
	logic [7:0]  rdata;
	logic [31:0] pin_in, pin_out, pin_oe_n, pin_pu, pin_an, pin_lvl;
	logic [31:0] ext    = 32'h08960000;
	logic [31:0] ext_en = 32'h08FF0040;
	logic        boost, rxd, psel, ppow;
	logic        i2c_en = 0, scl_low = 0, spi_en = 0, cmp_en = 0, cmp_out = 0;
	logic        u0 = 0, txd = 0, ch4 = 0, oc = 0, gdm = 0;
	logic [2:0]  spi_out = 3'h0, spi_oe = 3'h0;
	logic [5:2]  pwm = 4'h0, pwm_oe = 4'h0;
	logic [5:0]  t1 = 6'h0, t0 = 6'h0, foc = 6'h0, gate;
	int          n_fail = 0;
	int          checks = 0;
	localparam logic [15:0] ADR [0:17] = '{16'h0080, 16'h0090, 16'h00A0, 16'h00B0,
		16'h00F8, 16'h00FC, 16'h00FD, 16'h00FE, 16'h00FF, 16'h404C, 16'h404D,
		16'h4050, 16'h4051, 16'h4052, 16'h4053, 16'h4054, 16'h4055, 16'h4056};
	localparam logic [7:0] MSK [0:17] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h0F, 8'hFB, 8'hFF, 8'h3F, 8'hFF,
		8'hFF, 8'hFF, 8'hFF};

	always #20 I_CLK_SYS = ~I_CLK_SYS;

	gpm_pad_model pad_u (.i_clk(I_CLK_SYS), .i_out(pin_out), .i_oe_n(pin_oe_n),
		.i_pullup(pin_pu), .i_ext(ext), .i_ext_en(ext_en), .o_pad(pin_in));

	gpm_top dut_u (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_rmw(rmw), .o_rdata(rdata),
		.i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n),
		.o_pin_pullup(pin_pu), .o_pin_analog(pin_an), .o_pin_level(pin_lvl),
		.o_pin13_boost(boost), .i_i2c_en(i2c_en), .i_i2c_scl_low(scl_low),
		.i_spi_en(spi_en), .i_spi_out(spi_out), .i_spi_oe(spi_oe),
		.i_cmp_pin_en(cmp_en), .i_cmp_out(cmp_out), .i_uart_other_enable(u0),
		.i_uart_txd(txd), .o_uart_rxd(rxd), .i_timer_pwm(pwm),
		.i_timer_pwm_oe(pwm_oe), .i_timer0_ch4_compare_out(ch4),
		.i_timer1_oc(t1), .i_timer0_oc(t0), .i_foc_oc(foc),
		.i_over_current(oc), .i_gate_driver_mode(gdm), .o_gate(gate),
		.o_predriver_power(ppow), .o_drive_source_select(psel));

	task automatic tk(input int n);
		repeat (n) @(posedge I_CLK_SYS);
		#1;
	endtask : tk

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge I_CLK_SYS);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge I_CLK_SYS);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input string nm, input logic [15:0] a, input logic m,
		input logic [7:0] e);
		@(posedge I_CLK_SYS);
		addr <= a;
		rd   <= 1'b1;
		rmw  <= m;
		@(posedge I_CLK_SYS);
		rd  <= 1'b0;
		rmw <= 1'b0;
		#1;
		chk(nm, rdata, e);
	endtask : rd_chk

	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (100000) @(posedge I_CLK_SYS);
		n_fail++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge I_CLK_SYS);
		I_RST_N <= 1'b1;
		tk(1);
		chk("oe_n reset", pin_oe_n, 32'hFFFFFFFF);
		chk("rxd reset", rxd, 1'b1);
		chk("gate reset", gate, 6'h00);
		for (int i = 0; i < 18; i++) begin
			rd_chk("reg reset", ADR[i], i < 4, 8'h00);
			wr_reg(ADR[i], 8'hFF);
			rd_chk("reg mask", ADR[i], i < 4, MSK[i]);
			wr_reg(ADR[i], 8'h00);
		end
		wr_reg(16'h1234, 8'hFF);
		rd_chk("unmapped", 16'h1234, 1'b0, 8'h00);
		wr_reg(16'h00FE, 8'hA5);
		wr_reg(16'h4055, 8'h3C);
		wr_reg(16'h00A0, 8'hC3);
		tk(5);
		chk("port2_driver_enables_n", pin_oe_n[23:16], 8'h5A);
		chk("p2 pullup", pin_pu[23:16], 8'h3C);
		rd_chk("p2 pins", 16'h00A0, 1'b0, 8'h93);
		rd_chk("p2 latch", 16'h00A0, 1'b1, 8'hC3);
		wr_reg(16'h4051, 8'h0F);
		wr_reg(16'h4050, 8'hF0);
		wr_reg(16'h4052, 8'hFF);
		tk(5);
		chk("p2 analog", pin_an[23:16], 8'h0F);
		chk("port2_analog_select oe_n", pin_oe_n[23:16], 8'h5F);
		chk("p2 level", pin_lvl[23:16], 8'h90);
		rd_chk("port2_analog_select pins", 16'h00A0, 1'b0, 8'h90);
		rd_chk("port2_analog_select latch", 16'h00A0, 1'b1, 8'hC0);
		chk("p1 analog", pin_an[15:12], 4'hF);
		chk("p3 analog", pin_an[31:24], 8'h3F);
		// back to digital so P3.2 to P3.4 can be claimed later
		wr_reg(16'h4052, 8'h00);
		wr_reg(16'h0090, 8'h08);
		for (int k = 0; k < 4; k++) begin
			wr_reg(16'h4050, {4'h0, k[1], 3'h0});
			wr_reg(16'h00FD, {4'h0, k[0], 3'h0});
			tk(2);
			chk("p13 analog", pin_an[11], k[1] && !k[0]);
			chk("p13 boost", boost, k[1] && k[0]);
			chk("p13 oe_n", pin_oe_n[11], !k[0]);
		end
		wr_reg(16'h0080, 8'h01);
		wr_reg(16'h00FC, 8'h03);
		wr_reg(16'h4050, 8'h03);
		tk(2);
		chk("od oe_n", pin_oe_n[1:0], 2'b01);
		chk("od low", pin_out[1], 1'b0);
		wr_reg(16'h4050, 8'h00);
		tk(2);
		chk("pp oe_n", pin_oe_n[1:0], 2'b00);
		chk("pp out", pin_out[1:0], 2'b01);
		@(posedge I_CLK_SYS);
		t1  <= 6'h15;
		t0  <= 6'h2A;
		foc <= 6'h33;
		ch4 <= 1'b1;
		wr_reg(16'h404D, 8'h02);
		tk(2);
		chk("predrv on", ppow, 1'b1);
		@(posedge I_CLK_SYS);
		gdm <= 1'b1;
		tk(2);
		chk("predrv gdm", ppow, 1'b0);
		@(posedge I_CLK_SYS);
		gdm <= 1'b0;
		tk(25000);
		wr_reg(16'h404D, 8'h03);
		wr_reg(16'h00F8, 8'h2C);
		wr_reg(16'h404C, 8'h01);
		tk(2);
		chk("gate idle", gate, 6'h2C);
		chk("ch4 idle", {pin_oe_n[26], pin_out[26]}, 2'b00);
		wr_reg(16'h00F8, 8'hAC);
		for (int c = 0; c < 4; c++) begin
			wr_reg(16'h404D, {4'h0, c[1:0], 2'h3});
			tk(2);
			chk("gate src", gate, (c < 2) ? 6'h15 : (c == 2) ? 6'h2A : 6'h33);
			chk("ch4 cmp", pin_out[26], 1'b1);
		end
		wr_reg(16'h404D, 8'h0E);
		tk(2);
		chk("gates off", gate, 6'h00);
		wr_reg(16'h404D, 8'h0F);
		@(posedge I_CLK_SYS);
		oc <= 1'b1;
		tk(6);
		chk("oc select", psel, 1'b0);
		chk("oc gate", gate, 6'h2C);
		chk("oc ch4", pin_out[26], 1'b0);
		rd_chk("oc reg", 16'h00F8, 1'b0, 8'h2C);
		@(posedge I_CLK_SYS);
		oc      <= 1'b0;
		spi_en  <= 1'b1;
		spi_out <= 3'h3;
		spi_oe  <= 3'h7;
		pwm_oe  <= 4'hF;
		wr_reg(16'h0080, 8'hFF);
		wr_reg(16'h00FC, 8'hFF);
		wr_reg(16'h00B0, 8'hFF);
		wr_reg(16'h00FF, 8'hFF);
		wr_reg(16'h404C, 8'h00);
		tk(2);
		chk("spi pins", pin_out[7:5], 3'h3);
		@(posedge I_CLK_SYS);
		cmp_en  <= 1'b1;
		cmp_out <= 1'b1;
		tk(2);
		chk("cmp pin", pin_out[7], 1'b1);
		@(posedge I_CLK_SYS);
		cmp_en <= 1'b0;
		spi_en <= 1'b0;
		wr_reg(16'h404C, 8'h02);
		tk(2);
		chk("t5 pin", pin_out[7], 1'b0);
		@(posedge I_CLK_SYS);
		spi_en <= 1'b1;
		wr_reg(16'h404C, 8'h40);
		tk(5);
		chk("tx pin", pin_out[5], 1'b0);
		chk("rx oe_n", pin_oe_n[6], 1'b1);
		chk("rxd", rxd, 1'b0);
		chk("p34 gpio", pin_out[28], 1'b1);
		@(posedge I_CLK_SYS);
		u0 <= 1'b1;
		tk(2);
		chk("p34 tx", pin_out[28], 1'b0);
		@(posedge I_CLK_SYS);
		u0 <= 1'b0;
		wr_reg(16'h404C, 8'h20);
		tk(2);
		chk("alt tx", pin_out[28], 1'b0);
		wr_reg(16'h404C, 8'h10);
		tk(2);
		chk("t4 pin", pin_out[1], 1'b0);
		@(posedge I_CLK_SYS);
		i2c_en  <= 1'b1;
		scl_low <= 1'b1;
		tk(2);
		chk("scl low", {pin_oe_n[1], pin_out[1]}, 2'b00);
		@(posedge I_CLK_SYS);
		scl_low <= 1'b0;
		tk(2);
		chk("scl rel", pin_oe_n[1], 1'b1);
		wr_reg(16'h0090, 8'hFF);
		wr_reg(16'h00FD, 8'hFF);
		wr_reg(16'h404C, 8'h0C);
		@(posedge I_CLK_SYS);
		pwm <= 4'h1;
		tk(2);
		chk("t3 t2 pins", pin_out[9:8], 2'b01);
		end_sim();
	end
endmodule : gpm_top_tb

// *** design/gpm_map.svh ***
/*
 * Register offsets, field positions, write masks and reset values of the
 * port and gate-drive block.
 * Assumes one 16-bit address space for both the special-function and
 * extended register sets, with 8-bit data.
 */
`ifndef GPM_MAP_SVH
`define GPM_MAP_SVH

`define GPM_ADDR_W              16
`define GPM_SYNC_STAGES         2

`define GPM_OFS_PORT0_LATCH     16'h0080
`define GPM_OFS_PORT1_LATCH     16'h0090
`define GPM_OFS_PORT2_LATCH     16'h00A0
`define GPM_OFS_PORT3_LATCH     16'h00B0
`define GPM_OFS_GATE_LEVELS     16'h00F8
`define GPM_OFS_PORT0_OE        16'h00FC
`define GPM_OFS_PORT1_OE        16'h00FD
`define GPM_OFS_PORT2_OE        16'h00FE
`define GPM_OFS_PORT3_OE        16'h00FF
`define GPM_OFS_PIN_CLAIMS      16'h404C
`define GPM_OFS_DRIVE_CTL       16'h404D
`define GPM_OFS_PORT1_ANALOG    16'h4050
`define GPM_OFS_PORT2_ANALOG    16'h4051
`define GPM_OFS_PORT3_ANALOG    16'h4052
`define GPM_OFS_PORT0_PULLUP    16'h4053
`define GPM_OFS_PORT1_PULLUP    16'h4054
`define GPM_OFS_PORT2_PULLUP    16'h4055
`define GPM_OFS_PORT3_PULLUP    16'h4056

`define GPM_RST_BYTE            8'h00

`define GPM_MASK_PORT1_ANALOG   8'hFB
`define GPM_MASK_PORT3_ANALOG   8'h3F
`define GPM_MASK_DRIVE_CTL      8'h0F
`define GPM_MASK_PIN_CLAIMS     8'h7F

`define GPM_BIT_DRIVE_SOURCE    7
`define GPM_BIT_CH4_IDLE        6
`define GPM_BIT_PREDRV_ON       1
`define GPM_BIT_GATES_EN        0
`define GPM_BIT_PIN13_STRONG    3
`define GPM_BIT_PIN01_OD        1
`define GPM_BIT_PIN00_OD        0
`define GPM_BIT_UART_PRIMARY    6
`define GPM_BIT_UART_ALT        5
`define GPM_BIT_TIMER4_CLAIM    4
`define GPM_BIT_TIMER3_CLAIM    3
`define GPM_BIT_TIMER2_CLAIM    2
`define GPM_BIT_TIMER5_CLAIM    1
`define GPM_BIT_CH4_CLAIM       0

`define GPM_PIN_P0_0            0
`define GPM_PIN_P0_1            1
`define GPM_PIN_P0_5            5
`define GPM_PIN_P0_6            6
`define GPM_PIN_P0_7            7
`define GPM_PIN_P1_0            8
`define GPM_PIN_P1_1            9
`define GPM_PIN_P1_3            11
`define GPM_PIN_P3_2            26
`define GPM_PIN_P3_3            27
`define GPM_PIN_P3_4            28

`endif

// *** design/gpm_pkg.sv ***
/*
 * Types of the port and gate-drive block.
 * Assumes the offsets and fields live in gpm_map.svh.
 */
package gpm_pkg;

	typedef logic [7:0] gpm_byte_t;

	// source of the six internal phase signals
	typedef enum logic [1:0] {
		GPM_SRC_TIMER1_A = 2'h0,
		GPM_SRC_TIMER1_B = 2'h1,
		GPM_SRC_TIMER0   = 2'h2,
		GPM_SRC_FOC      = 2'h3
	} gpm_phase_src_t;

endpackage : gpm_pkg

// *** design/gpm_top.sv ***
/*
 * Four 8-bit ports with pull-ups, analog options on P1 to P3, open-drain on
 * P0.0 and P0.1, fixed priority pin sharing with peripherals, and the six-phase gate-drive mux.
 * Assumes peripheral and timer signals come from logic on I_CLK_SYS; pads
 * and the over-current comparator are asynchronous and are synchronised.
 */
`timescale 1ns/100ps
`include "gpm_map.svh"

// Notes on behaviour
// R1: output enable bit drives digital pin
// R2: pull-up bit switches pin pull-up
// R3: analog pin: digital off, reads zero
// R4: analog bits P1[7:4], P2 all, P3[5:0]
// R5: P1.3 mode from strong bit and enable
// R6: P0.0, P0.1 open-drain when bit set
// R7: gates follow idle bits or internal source
// R8: source field picks timer1, timer0 or FOC
// R9: over-current clears drive source bit
// R10: channel-4 pin: compare or idle level
// R11: predriver power bit, gates enable bit
// R12: software waits 1 ms before enabling gates
// R13: shared pins follow fixed ownership priority
// R14: primary UART outranks other UART enable
// R15: UART claim bits select pin pairs
// R16: timer claim bits take their pins
// R17: read-modify-write reads latch, not pin
// R18: owned pin ignores latch and enable
module gpm_top (
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_RST_N,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_rmw,
	output logic      [7:0]  o_rdata,
	input  wire logic [31:0] i_pin_in,
	output logic      [31:0] o_pin_out,
	output logic      [31:0] o_pin_oe_n,
	output logic      [31:0] o_pin_pullup,
	output logic      [31:0] o_pin_analog,
	output logic      [31:0] o_pin_level,
	output logic             o_pin13_boost,
	input  wire logic        i_i2c_en,
	input  wire logic        i_i2c_scl_low,
	input  wire logic        i_spi_en,
	input  wire logic [2:0]  i_spi_out,
	input  wire logic [2:0]  i_spi_oe,
	input  wire logic        i_cmp_pin_en,
	input  wire logic        i_cmp_out,
	input  wire logic        i_uart_other_enable,
	input  wire logic        i_uart_txd,
	output logic             o_uart_rxd,
	input  wire logic [5:2]  i_timer_pwm,
	input  wire logic [5:2]  i_timer_pwm_oe,
	input  wire logic        i_timer0_ch4_compare_out,
	input  wire logic [5:0]  i_timer1_oc,
	input  wire logic [5:0]  i_timer0_oc,
	input  wire logic [5:0]  i_foc_oc,
	input  wire logic        i_over_current,
	input  wire logic        i_gate_driver_mode,
	output logic      [5:0]  o_gate,
	output logic             o_predriver_power,
	output logic             o_drive_source_select
);

	logic        rst_meta_r;
	logic        rst_n_r;
	logic [31:0] pin_meta_r;
	logic [31:0] pin_sync_r;
	logic        oc_meta_r;
	logic        oc_sync_r;

	gpm_pkg::gpm_byte_t latch_r [4];
	gpm_pkg::gpm_byte_t oe_r    [4];
	gpm_pkg::gpm_byte_t pu_r    [4];
	gpm_pkg::gpm_byte_t port1_analog_and_drain_r;
	gpm_pkg::gpm_byte_t port2_analog_select_r;
	gpm_pkg::gpm_byte_t port3_analog_select_r;
	gpm_pkg::gpm_byte_t claims_r;
	gpm_pkg::gpm_byte_t gate_driver_control_r;
	logic        drive_source_select_r;
	logic [6:0]  idle_levels_r;

	logic [31:0] latch_all;
	logic [31:0] oe_all;
	logic [31:0] an_all;
	logic [31:0] own;
	logic [31:0] own_out;
	logic [31:0] own_oe;
	logic [31:0] pin_out_nxt;
	logic [31:0] pin_oe_nxt;
	logic [5:0]  internal_phase;
	logic [5:0]  gate_nxt;
	logic        pin13_analog;
	logic        uart_primary_pins_on;
	logic        uart_alternate_pins_on;
	logic        ch4_level;
	logic [7:0]  rdata_nxt;
	gpm_pkg::gpm_phase_src_t internal_phase_source;

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_meta_r <= 32'h0;
			pin_sync_r <= 32'h0;
			oc_meta_r  <= 1'b0;
			oc_sync_r  <= 1'b0;
		end else begin
			pin_meta_r <= i_pin_in;
			pin_sync_r <= pin_meta_r;
			oc_meta_r  <= i_over_current;
			oc_sync_r  <= oc_meta_r;
		end
	end

	// per-port latch, enable and pull-up registers
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_port
			always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
				if (!rst_n_r) begin
					latch_r[gp] <= `GPM_RST_BYTE;
					oe_r[gp]    <= `GPM_RST_BYTE;
					pu_r[gp]    <= `GPM_RST_BYTE;
				end else if (i_wr) begin
					// R17 latch written back
					if (i_addr == `GPM_OFS_PORT0_LATCH + 16'(gp * 16))
						latch_r[gp] <= i_wdata;
					if (i_addr == `GPM_OFS_PORT0_OE + 16'(gp))
						oe_r[gp] <= i_wdata;
					if (i_addr == `GPM_OFS_PORT0_PULLUP + 16'(gp))
						pu_r[gp] <= i_wdata;
				end
			end
			assign latch_all[gp*8 +: 8] = latch_r[gp];
			assign oe_all[gp*8 +: 8]    = oe_r[gp];
		end
	endgenerate

	always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			port1_analog_and_drain_r   <= `GPM_RST_BYTE;
			port2_analog_select_r   <= `GPM_RST_BYTE;
			port3_analog_select_r   <= `GPM_RST_BYTE;
			claims_r  <= `GPM_RST_BYTE;
			gate_driver_control_r <= `GPM_RST_BYTE;
		end else if (i_wr) begin
			// R4 analog bits per port
			if (i_addr == `GPM_OFS_PORT1_ANALOG)
				port1_analog_and_drain_r <= i_wdata & `GPM_MASK_PORT1_ANALOG;
			if (i_addr == `GPM_OFS_PORT2_ANALOG)
				port2_analog_select_r <= i_wdata;
			if (i_addr == `GPM_OFS_PORT3_ANALOG)
				port3_analog_select_r <= i_wdata & `GPM_MASK_PORT3_ANALOG;
			if (i_addr == `GPM_OFS_PIN_CLAIMS)
				claims_r <= i_wdata & `GPM_MASK_PIN_CLAIMS;
			if (i_addr == `GPM_OFS_DRIVE_CTL)
				gate_driver_control_r <= i_wdata & `GPM_MASK_DRIVE_CTL;
		end
	end

	// R9 over-current clear wins over write
	always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			drive_source_select_r <= 1'b0;
			idle_levels_r         <= 7'h00;
		end else begin
			if (oc_sync_r)
				drive_source_select_r <= 1'b0;
			else if (i_wr && i_addr == `GPM_OFS_GATE_LEVELS)
				drive_source_select_r <= i_wdata[`GPM_BIT_DRIVE_SOURCE];
			if (i_wr && i_addr == `GPM_OFS_GATE_LEVELS)
				idle_levels_r <= i_wdata[6:0];
		end
	end

	// R5 pin13 mode decode
	assign pin13_analog = port1_analog_and_drain_r[`GPM_BIT_PIN13_STRONG] & ~oe_r[1][3];
	// R3 analog pins lose digital function
	assign an_all = {port3_analog_select_r, port2_analog_select_r, port1_analog_and_drain_r[7:4], pin13_analog, 3'h0, 8'h00};

	// R15 UART claim bits
	assign uart_primary_pins_on   = claims_r[`GPM_BIT_UART_PRIMARY];
	assign uart_alternate_pins_on = claims_r[`GPM_BIT_UART_ALT];

	// R13 fixed priority pin ownership
	always_comb begin
		own     = 32'h0;
		own_out = 32'h0;
		own_oe  = 32'h0;
		// R16 timer4 below I2C on P0.1
		if (i_i2c_en) begin
			own[`GPM_PIN_P0_1]     = 1'b1;
			own_oe[`GPM_PIN_P0_1]  = i_i2c_scl_low;
		end else if (claims_r[`GPM_BIT_TIMER4_CLAIM]) begin
			own[`GPM_PIN_P0_1]     = 1'b1;
			own_out[`GPM_PIN_P0_1] = i_timer_pwm[4];
			own_oe[`GPM_PIN_P0_1]  = i_timer_pwm_oe[4];
		end
		// R14 primary UART on P0.5/P0.6
		if (uart_primary_pins_on) begin
			own[`GPM_PIN_P0_5]     = 1'b1;
			own_out[`GPM_PIN_P0_5] = i_uart_txd;
			own_oe[`GPM_PIN_P0_5]  = 1'b1;
			own[`GPM_PIN_P0_6]     = 1'b1;
		end else if (i_spi_en) begin
			own[`GPM_PIN_P0_6:`GPM_PIN_P0_5]     = 2'h3;
			own_out[`GPM_PIN_P0_6:`GPM_PIN_P0_5] = i_spi_out[1:0];
			own_oe[`GPM_PIN_P0_6:`GPM_PIN_P0_5]  = i_spi_oe[1:0];
		end
		if (i_cmp_pin_en) begin
			own[`GPM_PIN_P0_7]     = 1'b1;
			own_out[`GPM_PIN_P0_7] = i_cmp_out;
			own_oe[`GPM_PIN_P0_7]  = 1'b1;
		end else if (i_spi_en) begin
			own[`GPM_PIN_P0_7]     = 1'b1;
			own_out[`GPM_PIN_P0_7] = i_spi_out[2];
			own_oe[`GPM_PIN_P0_7]  = i_spi_oe[2];
		end else if (claims_r[`GPM_BIT_TIMER5_CLAIM]) begin
			own[`GPM_PIN_P0_7]     = 1'b1;
			own_out[`GPM_PIN_P0_7] = i_timer_pwm[5];
			own_oe[`GPM_PIN_P0_7]  = i_timer_pwm_oe[5];
		end
		// R16 timer2/timer3 claims
		if (claims_r[`GPM_BIT_TIMER2_CLAIM]) begin
			own[`GPM_PIN_P1_0]     = 1'b1;
			own_out[`GPM_PIN_P1_0] = i_timer_pwm[2];
			own_oe[`GPM_PIN_P1_0]  = i_timer_pwm_oe[2];
		end
		if (claims_r[`GPM_BIT_TIMER3_CLAIM]) begin
			own[`GPM_PIN_P1_1]     = 1'b1;
			own_out[`GPM_PIN_P1_1] = i_timer_pwm[3];
			own_oe[`GPM_PIN_P1_1]  = i_timer_pwm_oe[3];
		end
		// R10 channel-4 pin level
		if (claims_r[`GPM_BIT_CH4_CLAIM]) begin
			own[`GPM_PIN_P3_2]     = 1'b1;
			own_out[`GPM_PIN_P3_2] = ch4_level;
			own_oe[`GPM_PIN_P3_2]  = 1'b1;
		end
		// R14 both UART enables: P3.4 also transmits
		if (uart_alternate_pins_on || (uart_primary_pins_on && i_uart_other_enable)) begin
			own[`GPM_PIN_P3_4]     = 1'b1;
			own_out[`GPM_PIN_P3_4] = i_uart_txd;
			own_oe[`GPM_PIN_P3_4]  = 1'b1;
		end
		if (uart_alternate_pins_on)
			own[`GPM_PIN_P3_3] = 1'b1;
	end

	assign ch4_level = drive_source_select_r ? i_timer0_ch4_compare_out
		: idle_levels_r[`GPM_BIT_CH4_IDLE];

	always_comb begin
		// R18 owned pins ignore latch/enable
		pin_out_nxt = (own & own_out) | (~own & latch_all);
		// R1 enable only in digital mode
		pin_oe_nxt  = ((own & own_oe) | (~own & oe_all)) & ~an_all;
		// R6 open-drain: drive only a low
		if (port1_analog_and_drain_r[`GPM_BIT_PIN00_OD] && !own[`GPM_PIN_P0_0]) begin
			pin_oe_nxt[`GPM_PIN_P0_0]  = pin_oe_nxt[`GPM_PIN_P0_0] & ~latch_all[`GPM_PIN_P0_0];
			pin_out_nxt[`GPM_PIN_P0_0] = 1'b0;
		end
		if (port1_analog_and_drain_r[`GPM_BIT_PIN01_OD] && !own[`GPM_PIN_P0_1]) begin
			pin_oe_nxt[`GPM_PIN_P0_1]  = pin_oe_nxt[`GPM_PIN_P0_1] & ~latch_all[`GPM_PIN_P0_1];
			pin_out_nxt[`GPM_PIN_P0_1] = 1'b0;
		end
		if (i_i2c_en)
			pin_out_nxt[`GPM_PIN_P0_1] = 1'b0;
	end

	// R8 internal phase source mux
	assign internal_phase_source = gpm_pkg::gpm_phase_src_t'(gate_driver_control_r[3:2]);
	always_comb begin
		unique case (internal_phase_source)
			gpm_pkg::GPM_SRC_TIMER1_A,
			gpm_pkg::GPM_SRC_TIMER1_B: internal_phase = i_timer1_oc;
			gpm_pkg::GPM_SRC_TIMER0:   internal_phase = i_timer0_oc;
			gpm_pkg::GPM_SRC_FOC:      internal_phase = i_foc_oc;
		endcase
	end

	// R7 idle or internal; R11 enable gates
	assign gate_nxt = gate_driver_control_r[`GPM_BIT_GATES_EN]
		? (drive_source_select_r ? internal_phase : idle_levels_r[5:0]) : 6'h00;

	always_comb begin
		rdata_nxt = 8'h00;
		unique case (i_addr)
			// R3 analog bits read zero; R17 latch on rmw
			`GPM_OFS_PORT0_LATCH: rdata_nxt = i_rmw ? latch_r[0] : pin_sync_r[7:0];
			`GPM_OFS_PORT1_LATCH: rdata_nxt = (i_rmw ? latch_r[1] : pin_sync_r[15:8])
				& ~an_all[15:8];
			`GPM_OFS_PORT2_LATCH: rdata_nxt = (i_rmw ? latch_r[2] : pin_sync_r[23:16])
				& ~an_all[23:16];
			`GPM_OFS_PORT3_LATCH: rdata_nxt = (i_rmw ? latch_r[3] : pin_sync_r[31:24])
				& ~an_all[31:24];
			`GPM_OFS_GATE_LEVELS: rdata_nxt = {drive_source_select_r, idle_levels_r};
			`GPM_OFS_PORT0_OE:    rdata_nxt = oe_r[0];
			`GPM_OFS_PORT1_OE:    rdata_nxt = oe_r[1];
			`GPM_OFS_PORT2_OE:    rdata_nxt = oe_r[2];
			`GPM_OFS_PORT3_OE:    rdata_nxt = oe_r[3];
			`GPM_OFS_PIN_CLAIMS:  rdata_nxt = claims_r;
			`GPM_OFS_DRIVE_CTL:   rdata_nxt = gate_driver_control_r;
			`GPM_OFS_PORT1_ANALOG: rdata_nxt = port1_analog_and_drain_r;
			`GPM_OFS_PORT2_ANALOG: rdata_nxt = port2_analog_select_r;
			`GPM_OFS_PORT3_ANALOG: rdata_nxt = port3_analog_select_r;
			`GPM_OFS_PORT0_PULLUP: rdata_nxt = pu_r[0];
			`GPM_OFS_PORT1_PULLUP: rdata_nxt = pu_r[1];
			`GPM_OFS_PORT2_PULLUP: rdata_nxt = pu_r[2];
			`GPM_OFS_PORT3_PULLUP: rdata_nxt = pu_r[3];
			default:              rdata_nxt = 8'h00;
		endcase
		if (!i_rd)
			rdata_nxt = 8'h00;
	end

	always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= rdata_nxt;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_pin_out             <= 32'h0;
			o_pin_oe_n            <= 32'hFFFFFFFF;
			o_pin_pullup          <= 32'h0;
			o_pin_analog          <= 32'h0;
			o_pin_level           <= 32'h0;
			o_pin13_boost         <= 1'b0;
			o_uart_rxd            <= 1'b1;
			o_gate                <= 6'h00;
			o_predriver_power     <= 1'b0;
			o_drive_source_select <= 1'b0;
		end else begin
			o_pin_out    <= pin_out_nxt;
			o_pin_oe_n   <= ~pin_oe_nxt;
			// R2 pull-ups per pin
			o_pin_pullup <= {pu_r[3], pu_r[2], pu_r[1], pu_r[0]};
			o_pin_analog <= an_all;
			o_pin_level  <= pin_sync_r & ~an_all;
			// R5 boosted high drive
			o_pin13_boost <= port1_analog_and_drain_r[`GPM_BIT_PIN13_STRONG] & oe_r[1][3];
			// R14 receive from P0.6 first
			o_uart_rxd <= uart_primary_pins_on ? pin_sync_r[`GPM_PIN_P0_6]
				: (uart_alternate_pins_on ? pin_sync_r[`GPM_PIN_P3_3] : 1'b1);
			o_gate <= gate_nxt;
			// R11 power ignored in gate-driver mode
			o_predriver_power <= gate_driver_control_r[`GPM_BIT_PREDRV_ON] & ~i_gate_driver_mode;
			o_drive_source_select <= drive_source_select_r;
		end
	end

	oe_follow_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R1
		o_pin_oe_n[16] == !($past(oe_r[2][0]) && !$past(port2_analog_select_r[0])))
		else $error("P2.0 driver enable wrong");
	pullup_follow_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R2
		o_pin_pullup[31:24] == $past(pu_r[3]))
		else $error("P3 pull-ups wrong");
	analog_read_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R3
		(i_rd && i_addr == `GPM_OFS_PORT2_LATCH) |=> ((o_rdata & $past(port2_analog_select_r)) == 8'h00))
		else $error("analog bit read nonzero");
	pin13_mode_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R5
		(port1_analog_and_drain_r[3] && !oe_r[1][3]) |=> (o_pin_analog[11] && o_pin_oe_n[11] && !o_pin13_boost))
		else $error("P1.3 analog mode wrong");
	gate_idle_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R7
		(!drive_source_select_r && gate_driver_control_r[0]) |=> (o_gate == $past(idle_levels_r[5:0])))
		else $error("gates not at idle levels");
	oc_clear_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R9
		oc_sync_r |=> (!drive_source_select_r ##1 !o_drive_source_select))
		else $error("over-current did not clear drive source");
	// an analog P3.2 keeps its driver off even when claimed
	ch4_pin_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R10
		(claims_r[0] && !drive_source_select_r && !port3_analog_select_r[2])
		|=> (o_pin_out[26] == $past(idle_levels_r[6]) && !o_pin_oe_n[26]))
		else $error("channel-4 pin not at idle level");
	gates_off_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R11
		!gate_driver_control_r[0] |=> (o_gate == 6'h00))
		else $error("gates driven while disabled");
	i2c_first_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R13
		(i_i2c_en && !i_i2c_scl_low) |=> o_pin_oe_n[1])
		else $error("P0.1 not released to I2C");
	rmw_latch_a : assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_r) // R17
		(i_rd && i_rmw && i_addr == `GPM_OFS_PORT0_LATCH) |=> (o_rdata == $past(latch_r[0])))
		else $error("rmw read not from latch");

endmodule : gpm_top
